// file: rtl/ebtc_pkg.sv
package ebtc_pkg;

    // ********************************************************
    // Bus layout
    // ********************************************************
    localparam int WB_AW = 10;
    localparam int WB_DW = 32;
    localparam int IDX_W = 8;
    localparam int IDX_LSB = 2;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [WB_AW-1:0] adr;
        logic [3:0] sel;
        logic [WB_DW-1:0] dat;
    } ebtc_wb_req_s;

    // ********************************************************
    // Register indexes (byte address is four times the index)
    // ********************************************************
    localparam logic [IDX_W-1:0] IDX_COUNT = 8'h01;
    localparam logic [IDX_W-1:0] IDX_IRQ_CONTROL = 8'h0b;
    localparam logic [IDX_W-1:0] IDX_OPTION_CONFIG = 8'h81;
    localparam logic [IDX_W-1:0] IDX_PIN_CONFIG = 8'h20;

    // ********************************************************
    // Reset values
    // ********************************************************
    localparam logic [7:0] RST_COUNT = 8'h00;
    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_OPTION_CONFIG = 8'hff;
    localparam logic [7:0] RST_PIN_CONFIG = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int IRQ_GLOBAL_EN_BIT = 7;
    localparam int IRQ_OVF_EN_BIT = 5;
    localparam int IRQ_OVF_FLAG_BIT = 2;
    localparam int OPT_CLK_SRC_BIT = 5;
    localparam int OPT_EDGE_SEL_BIT = 4;
    localparam int OPT_PRESC_ASSIGN_BIT = 3;
    localparam int OPT_RATE_MSB = 2;
    localparam int PIN_DIGITAL_BIT = 0;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int PHASES_PER_INSN = 4;
    localparam int INHIBIT_INSNS = 2;
    localparam logic [1:0] PH_Q2 = 2'h1;
    localparam logic [1:0] PH_Q4 = 2'h3;

endpackage : ebtc_pkg

// file: rtl/ebtc_timer.sv
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/1ps
module ebtc_timer (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Register bus
    input ebtc_pkg::ebtc_wb_req_s wb_req,
    output logic [ebtc_pkg::WB_DW-1:0] wb_dat_o,
    output logic wb_ack_o,
    // Pin and core status
    input wire logic pin_two,
    input wire logic sleep_mode,
    // Interrupt towards the core
    output logic overflow_irq
);
    import ebtc_pkg::*;

    // ********************************************************
    // Functions
    // ********************************************************
    function automatic logic reg_hit(input logic [WB_AW-1:0] adr,
                                     input logic [IDX_W-1:0] idx);
        reg_hit = (adr[IDX_LSB+IDX_W-1:IDX_LSB] == idx);
    endfunction : reg_hit

    // ********************************************************
    // Bus slave
    // ********************************************************
    logic ack_ff;
    logic [WB_DW-1:0] rdat_ff;
    logic bus_req;
    logic bus_wr;
    logic lane0;
    logic cnt_wr;
    logic irq_wr;
    logic opt_wr;
    logic pin_wr;
    logic [7:0] wbyte;

    assign bus_req = wb_req.cyc & wb_req.stb;
    // Writes land on the edge where the master sees ack
    assign bus_wr = bus_req & wb_req.we & ack_ff;
    assign lane0 = wb_req.sel[0];
    assign wbyte = wb_req.dat[7:0];
    assign cnt_wr = bus_wr & lane0 & reg_hit(wb_req.adr, IDX_COUNT);
    assign irq_wr = bus_wr & lane0 & reg_hit(wb_req.adr, IDX_IRQ_CONTROL);
    assign opt_wr = bus_wr & lane0 & reg_hit(wb_req.adr, IDX_OPTION_CONFIG);
    assign pin_wr = bus_wr & lane0 & reg_hit(wb_req.adr, IDX_PIN_CONFIG);
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= bus_req & ~ack_ff;
        end
    end

    // ********************************************************
    // Configuration registers
    // ********************************************************
    logic [7:0] opt_ff;
    logic [7:0] pin_cfg_ff;
    logic [7:0] irq_ctl_ff;
    logic [7:0] count_ff;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            opt_ff <= RST_OPTION_CONFIG;
        end else if (opt_wr) begin
            opt_ff <= wbyte;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_cfg_ff <= RST_PIN_CONFIG;
        end else if (pin_wr) begin
            pin_cfg_ff <= wbyte;
        end
    end

    logic clk_src;
    logic edge_sel;
    logic presc_assign;
    logic [OPT_RATE_MSB:0] rate;
    assign clk_src = opt_ff[OPT_CLK_SRC_BIT];
    assign edge_sel = opt_ff[OPT_EDGE_SEL_BIT];
    assign presc_assign = opt_ff[OPT_PRESC_ASSIGN_BIT];
    assign rate = opt_ff[OPT_RATE_MSB:0];

    // Unmapped indexes answer with zero
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            rdat_ff <= '0;
        end else if (bus_req & ~ack_ff) begin
            rdat_ff <= '0;
            if (reg_hit(wb_req.adr, IDX_COUNT)) begin
                rdat_ff[7:0] <= count_ff;
            end else if (reg_hit(wb_req.adr, IDX_IRQ_CONTROL)) begin
                rdat_ff[7:0] <= irq_ctl_ff;
            end else if (reg_hit(wb_req.adr, IDX_OPTION_CONFIG)) begin
                rdat_ff[7:0] <= opt_ff;
            end else if (reg_hit(wb_req.adr, IDX_PIN_CONFIG)) begin
                rdat_ff[7:0] <= pin_cfg_ff;
            end
        end
    end

    // ********************************************************
    // Phase clocks and pin input
    // ********************************************************
    logic [1:0] phase_ff;
    logic pin_s1_ff;
    logic pin_s2_ff;
    logic pin_lvl;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= phase_ff + 2'h1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_s1_ff <= 1'b0;
            pin_s2_ff <= 1'b0;
        end else begin
            pin_s1_ff <= pin_two;
            pin_s2_ff <= pin_s1_ff;
        end
    end

    // An analog-configured pin reads low
    assign pin_lvl = pin_s2_ff & pin_cfg_ff[PIN_DIGITAL_BIT];

    // ********************************************************
    // Prescaler and synchroniser
    // ********************************************************
    logic src;
    logic src_d_ff;
    logic [7:0] presc_ff;
    logic presc_out;
    logic samp_ff;
    logic tick_ff;
    logic sample_now;

    // Timer source is high during phases three and four
    assign src = clk_src ? (pin_lvl ^ edge_sel) : phase_ff[1];

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            src_d_ff <= 1'b1;
        end else begin
            src_d_ff <= src;
        end
    end

    // Not visible to software; only a count write clears it, and only while it is assigned to the timer
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            presc_ff <= 8'h00;
        end else if (cnt_wr & ~presc_assign) begin
            presc_ff <= 8'h00;
        end else if (~presc_assign & src & ~src_d_ff) begin
            presc_ff <= presc_ff + 8'h01;
        end
    end

    // Bit n toggles every 2**n edges, giving 1:2**(n+1)
    assign presc_out = presc_assign ? src : presc_ff[rate];

    assign sample_now = (phase_ff == PH_Q2) || (phase_ff == PH_Q4);

    // Reset options hold the source high; start high to avoid a false tick
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            samp_ff <= 1'b1;
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= sample_now & presc_out & ~samp_ff;
            if (sample_now) begin
                samp_ff <= presc_out;
            end
        end
    end

    // ********************************************************
    // Count register
    // ********************************************************
    logic [1:0] inhibit_ff;
    logic advance;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            inhibit_ff <= 2'h0;
        end else if (cnt_wr) begin
            inhibit_ff <= 2'(INHIBIT_INSNS);
        end else if (phase_ff == PH_Q4 && inhibit_ff != 2'h0) begin
            inhibit_ff <= inhibit_ff - 2'h1;
        end
    end

    // Sleep freezes the count, so no overflow can wake the core
    assign advance = tick_ff & (inhibit_ff == 2'h0) & ~sleep_mode;

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            count_ff <= RST_COUNT;
        end else if (cnt_wr) begin
            count_ff <= wbyte;
        end else if (advance) begin
            count_ff <= count_ff + 8'h01;
        end
    end

    // ********************************************************
    // Interrupt control
    // ********************************************************
    logic ovf_set;
    assign ovf_set = advance & (count_ff == COUNT_MAX);

    // A wrap in the same cycle as a clearing write keeps the flag
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_ctl_ff <= RST_IRQ_CONTROL;
        end else if (irq_wr) begin
            irq_ctl_ff <= wbyte;
            irq_ctl_ff[IRQ_OVF_FLAG_BIT] <=
                wbyte[IRQ_OVF_FLAG_BIT] | ovf_set;
        end else if (ovf_set) begin
            irq_ctl_ff[IRQ_OVF_FLAG_BIT] <= 1'b1;
        end
    end

    logic irq_ff;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= irq_ctl_ff[IRQ_GLOBAL_EN_BIT]
                & irq_ctl_ff[IRQ_OVF_EN_BIT]
                & irq_ctl_ff[IRQ_OVF_FLAG_BIT];
        end
    end
    assign overflow_irq = irq_ff;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    sequence s_wrap;
        advance && !cnt_wr && count_ff == COUNT_MAX;
    endsequence

    sequence s_count_write;
        cnt_wr;
    endsequence

    AST_WRAP: assert property (s_wrap |=> count_ff == 8'h00)
        else $error("count did not wrap to zero");

    AST_OVF_FLAG: assert property (
        s_wrap |=> irq_ctl_ff[IRQ_OVF_FLAG_BIT])
        else $error("overflow flag not set on wrap");

    AST_INHIBIT_LOAD: assert property (
        s_count_write |=> inhibit_ff == 2'h2 && count_ff == $past(wbyte))
        else $error("count write did not load and hold");

    AST_INHIBIT_HOLD: assert property (
        (inhibit_ff != 2'h0 && !cnt_wr) |=> $stable(count_ff))
        else $error("count advanced while held off");

    AST_SLEEP: assert property (
        (sleep_mode && !cnt_wr) |=> $stable(count_ff))
        else $error("count advanced during sleep");

    AST_FLAG_STICKY: assert property (
        (irq_ctl_ff[IRQ_OVF_FLAG_BIT] && !irq_wr)
        |=> irq_ctl_ff[IRQ_OVF_FLAG_BIT])
        else $error("overflow flag dropped without software");

    AST_IRQ_GATE: assert property (
        overflow_irq |-> $past(irq_ctl_ff[IRQ_OVF_EN_BIT])
        && $past(irq_ctl_ff[IRQ_GLOBAL_EN_BIT]))
        else $error("interrupt raised while masked");

    AST_IRQ_RAISE: assert property (
        ($rose(irq_ctl_ff[IRQ_OVF_FLAG_BIT])
        && irq_ctl_ff[IRQ_OVF_EN_BIT] && irq_ctl_ff[IRQ_GLOBAL_EN_BIT])
        |=> overflow_irq)
        else $error("enabled overflow did not interrupt");

    AST_SAMPLE_PHASE: assert property (
        tick_ff |-> (phase_ff == 2'h2 || phase_ff == 2'h0))
        else $error("count tick off the sampling phases");

    AST_PRESC_CLEAR: assert property (
        (cnt_wr && !presc_assign) |=> presc_ff == 8'h00)
        else $error("prescaler not cleared by count write");

    AST_ACK_PULSE: assert property (
        bus_req && !ack_ff |=> ack_ff ##1 !ack_ff)
        else $error("bus ack not a single cycle");

endmodule : ebtc_timer

// file: tb/ebtc_clk_src.sv
`timescale 1ns/1ps
// ****************************
// External count clock source
// ****************************
module ebtc_clk_src (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_b,
    // Frame request
    input wire logic go,
    input wire logic [3:0] toggles,
    input wire logic [3:0] half,
    // Pin side
    output logic pin,
    output logic busy
);
    int hold;

    // Stands still between frames, so stray edges come only from the bench
    always @(posedge mclk) begin
        if (!rst_b) begin
            pin <= 1'b0;
            busy <= 1'b0;
        end else if (go && !busy) begin
            busy <= 1'b1;
            hold = (half < 4'h2) ? 2 : int'(half);
            repeat (toggles) begin
                repeat (hold) @(posedge mclk);
                pin <= ~pin;
            end
            busy <= 1'b0;
        end
    end
endmodule : ebtc_clk_src

// file: tb/ebtc_timer_test.sv
`timescale 1ns/1ps
// ****************************
// Timer/counter bench
// ****************************
module ebtc_timer_test;
    import ebtc_pkg::*;
    logic mclk;
    logic rst_b;
    ebtc_wb_req_s wb_req;
    logic [WB_DW-1:0] wb_dat_o;
    logic wb_ack_o;
    logic pin_two;
    logic sleep_mode;
    logic overflow_irq;
    logic go;
    logic [3:0] toggles;
    logic src_busy;
    int error_cnt = 0;
    int comparisons = 0;
    int cyc_cnt = 0;
    int t_ack;

    ebtc_timer ebtc_timer_inst (.mclk(mclk), .rst_b(rst_b),
        .wb_req(wb_req), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .pin_two(pin_two), .sleep_mode(sleep_mode),
        .overflow_irq(overflow_irq));
    ebtc_clk_src ebtc_clk_src_inst (.mclk(mclk), .rst_b(rst_b), .go(go),
        .toggles(toggles), .half(4'h4), .pin(pin_two), .busy(src_busy));

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // The sequence needs well under two thousand cycles; far beyond that is a hang
    always @(posedge mclk) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    task automatic complete_run();
        if (error_cnt == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wb_xfer(input logic we, input logic [7:0] idx,
                           input logic [7:0] wd, output logic [7:0] rd);
        @(posedge mclk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00},
                    sel: 4'h1, dat: {24'h0, wd}};
        // Only the bench timeout ends a wait for ack
        do begin
            @(posedge mclk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        t_ack = cyc_cnt;
        wb_req <= '0;
    endtask : wb_xfer

    task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
        logic [7:0] x;
        wb_xfer(1'b1, idx, d, x);
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] idx, output logic [7:0] d);
        wb_xfer(1'b0, idx, 8'h00, d);
    endtask : reg_rd

    // Count gained between two reads some 128 cycles apart
    task automatic delta(input string what, input int period);
        logic [7:0] a;
        logic [7:0] b;
        int t0;
        reg_rd(IDX_COUNT, a);
        t0 = t_ack;
        while (cyc_cnt < t0 + 125) @(posedge mclk);
        reg_rd(IDX_COUNT, b);
        check(what, b - a, (period == 0) ? 8'h00 : 8'((t_ack - t0) / period));
    endtask : delta

    // Count write clears the prescaler when it is assigned to the timer, and any switch-over glitch
    task automatic set_mode(input logic [7:0] opt);
        reg_wr(IDX_OPTION_CONFIG, opt);
        reg_wr(IDX_COUNT, 8'h00);
        repeat (12) @(posedge mclk);
    endtask : set_mode

    task automatic t_reset();
        logic [7:0] d;
        reg_rd(IDX_COUNT, d);
        check("count", d, RST_COUNT);
        reg_rd(IDX_IRQ_CONTROL, d);
        check("irq_control", d, RST_IRQ_CONTROL);
        reg_rd(IDX_OPTION_CONFIG, d);
        check("option_config", d, RST_OPTION_CONFIG);
        reg_rd(IDX_PIN_CONFIG, d);
        check("pin_config", d, RST_PIN_CONFIG);
        reg_wr(8'h3f, 8'h5a);
        reg_rd(8'h3f, d);
        check("unmapped", d, 8'h00);
    endtask : t_reset

    task automatic t_pin(input logic edge_sel, input logic digital,
                         input logic [3:0] n, input logic [7:0] exp);
        logic [7:0] d;
        reg_wr(IDX_PIN_CONFIG, {7'h0, digital});
        reg_wr(IDX_OPTION_CONFIG, {2'b00, 1'b1, edge_sel, 4'h8});
        // Clear after the mode change, which may itself look like an edge
        reg_wr(IDX_COUNT, 8'h00);
        repeat (12) @(posedge mclk);
        toggles <= n;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (60) begin
            @(posedge mclk);
            if (src_busy !== 1'b1)
                break;
        end
        repeat (12) @(posedge mclk);
        reg_rd(IDX_COUNT, d);
        check("pin count", d, exp);
    endtask : t_pin

    task automatic t_timer();
        set_mode(8'h08);
        delta("timer step", 4);
        @(posedge mclk);
        sleep_mode <= 1'b1;
        delta("sleep step", 0);
        sleep_mode <= 1'b0;
        for (int n = 0; n < 5; n++) begin
            set_mode(8'(n));
            delta("prescaled step", 8 << n);
        end
    endtask : t_timer

    task automatic t_hold();
        logic [7:0] d;
        reg_wr(IDX_OPTION_CONFIG, 8'h08);
        reg_wr(IDX_IRQ_CONTROL, 8'ha0);
        reg_wr(IDX_COUNT, 8'hfe);
        reg_rd(IDX_COUNT, d);
        check("count", d, 8'hfe);
        reg_rd(IDX_IRQ_CONTROL, d);
        check("early flag", d, 8'ha0);
        repeat (30) @(posedge mclk);
        reg_rd(IDX_IRQ_CONTROL, d);
        check("wrap flag", d, 8'ha4);
        check("overflow_irq", {7'h0, overflow_irq}, 8'h01);
    endtask : t_hold

    task automatic irq_step(input logic [7:0] v, input logic exp);
        reg_wr(IDX_IRQ_CONTROL, v);
        repeat (2) @(posedge mclk);
        check("overflow_irq", {7'h0, overflow_irq}, {7'h0, exp});
    endtask : irq_step

    task automatic t_irq();
        logic [7:0] d;
        irq_step(8'h24, 1'b0);
        irq_step(8'ha4, 1'b1);
        irq_step(8'h84, 1'b0);
        irq_step(8'ha4, 1'b1);
        irq_step(8'ha0, 1'b0);
        reg_rd(IDX_IRQ_CONTROL, d);
        check("irq_control", d, 8'ha0);
    endtask : t_irq

    initial begin
        rst_b = 1'b0;
        wb_req = '0;
        sleep_mode = 1'b0;
        go = 1'b0;
        toggles = 4'h0;
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        t_reset();
        t_pin(1'b0, 1'b0, 4'h5, 8'h00);
        t_pin(1'b0, 1'b1, 4'h4, 8'h02);
        t_pin(1'b1, 1'b1, 4'h3, 8'h02);
        t_timer();
        t_hold();
        t_irq();
        complete_run();
    end
endmodule : ebtc_timer_test
